// [core/aclm_lane_mapper.sv]
`timescale 1ns/1ps
module aclm_lane_mapper
  import aclm_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire logic [ADDR_W-1:0]                 s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [ADDR_W-1:0]                 s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [N_CH-1:0][SAMPLE_W-1:0]     converter_input_channel,
  input  wire logic                              sample_valid,
  output logic                                   sample_ready,
  output logic [N_POS-1:0][SAMPLE_W-1:0]         position_lane_a,
  output logic [N_POS-1:0][SAMPLE_W-1:0]         position_lane_b,
  output logic [N_LANE-1:0]                      lane_data_present,
  output logic [N_LANE-1:0]                      lane_power_down,
  output logic                                   lane_valid,
  input  wire logic                              lane_ready
);

  // configuration and bus state
  logic [MAP_W-1:0]                map_ff [N_MAP];
  logic                            two_lane_ff;
  logic                            awready_ff;
  logic                            wready_ff;
  logic [ADDR_W-1:0]               awaddr_ff;
  logic [31:0]                     wdata_ff;
  logic [3:0]                      wstrb_ff;
  logic                            bvalid_ff;
  logic [1:0]                      bresp_ff;
  logic                            arready_ff;
  logic                            rvalid_ff;
  logic [31:0]                     rdata_ff;
  logic [1:0]                      rresp_ff;
  logic [N_LANE-1:0]               pd_ff;

  // two-entry buffer state
  logic                            in_ready_ff;
  logic                            out_valid_ff;
  logic                            skid_valid_ff;
  logic [N_LANE-1:0][SAMPLE_W-1:0] out_data_ff;
  logic [N_LANE-1:0]               out_pres_ff;
  logic [N_LANE-1:0][SAMPLE_W-1:0] skid_data_ff;
  logic [N_LANE-1:0]               skid_pres_ff;
  logic                            nxt_out_valid;
  logic                            nxt_skid_valid;
  logic [N_LANE-1:0][SAMPLE_W-1:0] nxt_out_data;
  logic [N_LANE-1:0]               nxt_out_pres;
  logic [N_LANE-1:0][SAMPLE_W-1:0] nxt_skid_data;
  logic [N_LANE-1:0]               nxt_skid_pres;

  // lane crossbar results
  logic [N_LANE-1:0][SAMPLE_W-1:0] mux_data;
  logic [N_LANE-1:0]               mux_pres;
  logic [N_LANE-1:0]               mux_pd;

  // write decode: both address and data held, no response pending
  wire              wr_go     = ~awready_ff & ~wready_ff & ~bvalid_ff;
  wire [7:0]        wr_idx    = awaddr_ff[9:2];
  wire              wr_hi_ok  = (awaddr_ff[ADDR_W-1:10] == 2'h0);
  wire              wr_is_map = wr_hi_ok & (wr_idx >= IDX_MAP_FIRST) & (wr_idx <= IDX_MAP_LAST);
  wire              wr_is_ctl = wr_hi_ok & (wr_idx == IDX_CTRL);
  wire              wr_is_st  = wr_hi_ok & (wr_idx == IDX_STATUS);
  wire [7:0]        wr_off    = wr_idx - IDX_MAP_FIRST;
  wire [2:0]        wr_sel    = wr_off[2:0];
  wire              wr_hit    = wr_is_map | wr_is_ctl | wr_is_st;

  // read decode
  wire              rd_go     = s_axi_arvalid & arready_ff;
  wire [7:0]        rd_idx    = s_axi_araddr[9:2];
  wire              rd_hi_ok  = (s_axi_araddr[ADDR_W-1:10] == 2'h0);
  wire              rd_is_map = rd_hi_ok & (rd_idx >= IDX_MAP_FIRST) & (rd_idx <= IDX_MAP_LAST);
  wire              rd_is_ctl = rd_hi_ok & (rd_idx == IDX_CTRL);
  wire              rd_is_st  = rd_hi_ok & (rd_idx == IDX_STATUS);
  wire [7:0]        rd_off    = rd_idx - IDX_MAP_FIRST;
  wire [2:0]        rd_sel    = rd_off[2:0];
  wire [31:0]       rd_map    = {20'h0, map_ff[rd_sel]};
  wire [31:0]       rd_ctl    = {31'h0, two_lane_ff};
  wire [31:0]       rd_st     = {14'h0, out_valid_ff, skid_valid_ff, out_pres_ff};
  wire [31:0]       rd_word   = rd_is_map ? rd_map :
                                rd_is_ctl ? rd_ctl :
                                rd_is_st  ? rd_st  : 32'h0;
  wire [1:0]        rd_resp   = (rd_is_map | rd_is_ctl | rd_is_st) ? RESP_OKAY : RESP_DECERR;

  // byte lanes of the 12-bit map word and the write merge
  wire [MAP_W-1:0]  wr_mask   = {{4{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [MAP_W-1:0]  wr_merge  = (map_ff[wr_sel] & ~wr_mask) | (wdata_ff[MAP_W-1:0] & wr_mask);

  // buffer handshakes
  wire              in_fire   = sample_valid & in_ready_ff;
  wire              out_free  = ~out_valid_ff | lane_ready;

  // write address and data channels, taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      awready_ff <= 1'h1;
      wready_ff  <= 1'h1;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid & awready_ff) begin
        awaddr_ff  <= s_axi_awaddr;
        awready_ff <= 1'h0;
      end
      if (s_axi_wvalid & wready_ff) begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        wready_ff <= 1'h0;
      end
      if (bvalid_ff & s_axi_bready) begin
        awready_ff <= 1'h1;
        wready_ff  <= 1'h1;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_ff <= 1'h0;
      bresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_ff <= 1'h1;
        bresp_ff  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // select fields, three per register, straight map after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int r = 0; r < N_MAP; r++) begin
        map_ff[r] <= MAP_RST[r];
      end
    end else if (ce && wr_go && wr_is_map) begin
      map_ff[wr_sel] <= wr_merge;
    end
  end

  // lane mode control bit; status register ignores writes
  always_ff @(posedge clk) begin
    if (rst) begin
      two_lane_ff <= CTRL_TWO_LANE_RST;
    end else if (ce && wr_go && wr_is_ctl && wstrb_ff[0]) begin
      two_lane_ff <= wdata_ff[CTRL_TWO_LANE_BIT];
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_ff <= 1'h1;
      rvalid_ff  <= 1'h0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rdata_ff   <= rd_word;
        rresp_ff   <= rd_resp;
        rvalid_ff  <= 1'h1;
        arready_ff <= 1'h0;
      end else if (rvalid_ff & s_axi_rready) begin
        rvalid_ff  <= 1'h0;
        arready_ff <= 1'h1;
      end
    end
  end

  // one crossbar slice per lane
  for (genvar l = 0; l < N_LANE; l++) begin : g_lane
    localparam int SLOT = LANE_SLOT[l];
    localparam int REGN = SLOT / FIELDS_PER;
    localparam int FLD  = SLOT % FIELDS_PER;
    wire [SEL_W-1:0]    code  = map_ff[REGN][FLD*SEL_W +: SEL_W];
    wire [1:0]          pick  = code[2:1];
    // upper group counts down from channel 8, lower group up from channel 1
    wire [2:0]          chan  = (l >= UPPER_LANE) ? {1'h1, ~pick} : {1'h0, pick};
    wire [SAMPLE_W-1:0] smp   = converter_input_channel[chan];
    wire                high  = code[SEL_HI_BIT];
    wire                pdown = code[SEL_PD_BIT];
    // high-byte codes carry nothing in one-lane mode
    wire                live  = ~pdown & (two_lane_ff | ~high);
    wire [HALF_W-1:0]   half  = high ? smp[SAMPLE_W-1:HALF_W] : smp[HALF_W-1:0];
    wire [SAMPLE_W-1:0] word  = two_lane_ff ? {{(SAMPLE_W-HALF_W){1'h0}}, half} : smp;
    assign mux_data[l] = live ? word : '0;
    assign mux_pres[l] = live;
    assign mux_pd[l]   = pdown;
  end

  // lane buffer power-down follows the select msb
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_ff <= '0;
    end else if (ce) begin
      pd_ff <= mux_pd;
    end
  end

  // two-entry buffer: output stage plus skid stage
  always_comb begin
    nxt_out_valid  = out_valid_ff;
    nxt_out_data   = out_data_ff;
    nxt_out_pres   = out_pres_ff;
    nxt_skid_valid = skid_valid_ff;
    nxt_skid_data  = skid_data_ff;
    nxt_skid_pres  = skid_pres_ff;
    if (out_free) begin
      if (skid_valid_ff) begin
        nxt_out_valid  = 1'h1;
        nxt_out_data   = skid_data_ff;
        nxt_out_pres   = skid_pres_ff;
        nxt_skid_valid = 1'h0;
      end else begin
        nxt_out_valid = in_fire;
        if (in_fire) begin
          nxt_out_data = mux_data;
          nxt_out_pres = mux_pres;
        end
      end
    end else if (in_fire) begin
      nxt_skid_valid = 1'h1;
      nxt_skid_data  = mux_data;
      nxt_skid_pres  = mux_pres;
    end
  end

  // buffer registers; input ready drops while the skid stage is full
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_ff  <= 1'h0;
      skid_valid_ff <= 1'h0;
      in_ready_ff   <= 1'h1;
      out_data_ff   <= '0;
      out_pres_ff   <= '0;
      skid_data_ff  <= '0;
      skid_pres_ff  <= '0;
    end else if (ce) begin
      out_valid_ff  <= nxt_out_valid;
      skid_valid_ff <= nxt_skid_valid;
      in_ready_ff   <= ~nxt_skid_valid;
      out_data_ff   <= nxt_out_data;
      out_pres_ff   <= nxt_out_pres;
      skid_data_ff  <= nxt_skid_data;
      skid_pres_ff  <= nxt_skid_pres;
    end
  end

  // lane A is the even lane of each position, lane B the odd one
  for (genvar p = 0; p < N_POS; p++) begin : g_pos
    assign position_lane_a[p] = out_data_ff[2*p];
    assign position_lane_b[p] = out_data_ff[2*p+1];
  end

  // port drivers, all from flops
  assign s_axi_awready     = awready_ff;
  assign s_axi_wready      = wready_ff;
  assign s_axi_bvalid      = bvalid_ff;
  assign s_axi_bresp       = bresp_ff;
  assign s_axi_arready     = arready_ff;
  assign s_axi_rvalid      = rvalid_ff;
  assign s_axi_rdata       = rdata_ff;
  assign s_axi_rresp       = rresp_ff;
  assign sample_ready      = in_ready_ff;
  assign lane_valid        = out_valid_ff;
  assign lane_data_present = out_pres_ff;
  assign lane_power_down   = pd_ff;

endmodule : aclm_lane_mapper

// [core/aclm_pkg.sv]
// Function
// - upper group codes 0000/0001 carry channel 8, low byte / high byte.
// - upper group codes 0010/0011 carry channel 7, low byte / high byte.
// - upper group codes 0100/0101 carry channel 6, low byte / high byte.
// - upper group codes 0110/0111 carry channel 5, low byte / high byte.
// - select msb set powers the lane down, lower bits ignored.
// - reset map, one-lane mode: channel k only on lane A of position k.
// - reset map, two-lane mode: channel k spread over lanes A and B of k.
// - lower group codes 0/2/4/6 carry channels 1-4, odd codes high byte.
// - channels 1-4 reach positions 1-4 only, channels 5-8 positions 5-8 only.
// - sixteen 4-bit selects live at indices 0x50-0x55, three per register.
package aclm_pkg;
  localparam int SAMPLE_W   = 14;
  localparam int HALF_W     = 7;
  localparam int N_CH       = 8;
  localparam int N_POS      = 8;
  localparam int N_LANE     = 16;
  localparam int SEL_W      = 4;
  localparam int N_MAP      = 6;
  localparam int FIELDS_PER = 3;
  localparam int MAP_W      = 12;
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 12;
  localparam int UPPER_LANE = 8;
  localparam int SEL_PD_BIT = 3;
  localparam int SEL_HI_BIT = 0;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MAP_FIRST = 8'h50;
  localparam logic [7:0] IDX_MAP_LAST  = 8'h55;
  localparam logic [7:0] IDX_CTRL      = 8'h56;
  localparam logic [7:0] IDX_STATUS    = 8'h57;
  localparam int CTRL_TWO_LANE_BIT = 0;
  localparam int STAT_SKID_BIT     = 16;
  localparam int STAT_OUT_BIT      = 17;
  localparam logic CTRL_TWO_LANE_RST = 1'h0;
  // field slot (register * 3 + field) of each lane, lane = 2 * position + (lane B)
  localparam int LANE_SLOT [N_LANE] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 9, 12, 11, 14, 13, 16, 15};
  // straight map: lane A even code, lane B odd code of the same channel
  localparam logic [MAP_W-1:0] MAP_RST [N_MAP] = '{12'h210, 12'h543, 12'h076,
                                                  12'h567, 12'h234, 12'h001};
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : aclm_pkg

// [verification/aclm_lane_mapper_chk.sv]
`timescale 1ns/1ps
module aclm_lane_mapper_chk
  import aclm_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic [ADDR_W-1:0]             s_axi_araddr,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [N_POS-1:0][SAMPLE_W-1:0] position_lane_a,
  input wire logic [N_POS-1:0][SAMPLE_W-1:0] position_lane_b,
  input wire logic [N_LANE-1:0]             lane_data_present,
  input wire logic [N_LANE-1:0]             lane_power_down,
  input wire logic                          lane_valid,
  input wire logic                          lane_ready
);
  logic [N_LANE-1:0] lane_nz;
  logic              rd_hit;
  // lanes holding a non-zero value, same bit order as present
  for (genvar p = 0; p < N_POS; p++) begin : g_nz
    assign lane_nz[2*p]   = |position_lane_a[p];
    assign lane_nz[2*p+1] = |position_lane_b[p];
  end
  // read address lands on a decoded register
  assign rd_hit = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[9:2] >= IDX_MAP_FIRST) &&
                  (s_axi_araddr[9:2] <= IDX_STATUS);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // response rises on the second edge after both halves are taken
  chk_wr_answer: assert property (wr_both |=>
    (!s_axi_bvalid && !s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after take");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_unmapped_rd: assert property ((rd_take and !rd_hit) |=>
    s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_lane_hold: assert property (lane_valid && !lane_ready |=> lane_valid &&
    $stable(position_lane_a) && $stable(position_lane_b) && $stable(lane_data_present))
    else $error("lane word changed while stalled");
  chk_idle_zero: assert property (lane_valid |-> (lane_nz & ~lane_data_present) == 16'h0)
    else $error("idle lane carries data");
  chk_pd_silent: assert property ($rose(lane_valid) |-> (lane_power_down & lane_data_present) == 16'h0)
    else $error("powered down lane carries data");
  chk_rst_vals: assert property ($fell(rst) |-> s_axi_awready && !s_axi_bvalid && !lane_valid && lane_power_down == 16'h0)
    else $error("reset state wrong");
endmodule : aclm_lane_mapper_chk

// [verification/aclm_lane_sink.sv]
`timescale 1ns/1ps
module aclm_lane_sink
  import aclm_pkg::*;
(
  input wire logic                           clk,
  input wire logic                           stall,
  input wire logic [N_POS-1:0][SAMPLE_W-1:0] position_lane_a,
  input wire logic [N_POS-1:0][SAMPLE_W-1:0] position_lane_b,
  input wire logic [N_LANE-1:0]              lane_data_present,
  input wire logic                           lane_valid,
  output logic                               lane_ready
);
  logic [239:0] q [$];
  initial lane_ready = 1'b0;
  // receiver capture: ready unless stalled, every accepted word queued
  always @(posedge clk) begin
    if (lane_valid && lane_ready) q.push_back({position_lane_a, position_lane_b, lane_data_present});
    lane_ready <= !stall;
  end
endmodule : aclm_lane_sink

// [verification/aclm_lane_mapper_tb_top.sv]
`timescale 1ns/1ps
module aclm_lane_mapper_tb_top
  import aclm_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, stall = 1'b0, lane_ready;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, sample_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_ready;
  logic lane_valid;
  logic lag = 1'b0; // late bready/rready so held answers get exercised
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [N_CH-1:0][SAMPLE_W-1:0] converter_input_channel = '0;
  logic [N_POS-1:0][SAMPLE_W-1:0] position_lane_a, position_lane_b;
  logic [N_LANE-1:0] lane_data_present, lane_power_down;
  int num_errors = 0, tests_run = 0, cyc = 0;
  aclm_lane_mapper dut (.clk, .rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .converter_input_channel, .sample_valid, .sample_ready,
    .position_lane_a, .position_lane_b, .lane_data_present, .lane_power_down, .lane_valid,
    .lane_ready);
  aclm_lane_sink sink (.clk, .stall, .position_lane_a, .position_lane_b, .lane_data_present,
    .lane_valid, .lane_ready);
  // clock and hang guard
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [239:0] got, input logic [239:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !lag;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    if (lag) begin
      repeat (3) @(posedge clk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !lag;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    if (lag) begin
      repeat (3) @(posedge clk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic send(input logic [N_CH-1:0][SAMPLE_W-1:0] v);
    converter_input_channel <= v;
    sample_valid <= 1'b1;
    do @(posedge clk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
    @(posedge clk);
  endtask : send
  task automatic take(output logic [239:0] w);
    while (sink.q.size() == 0) @(posedge clk);
    w = sink.q.pop_front();
  endtask : take
  function automatic logic [N_CH-1:0][SAMPLE_W-1:0] mk(input int j);
    logic [N_CH-1:0][SAMPLE_W-1:0] s;
    for (int k = 0; k < N_CH; k++) s[k] = 14'(j * 14'h0123 + k * 14'h02D1 + 14'h01A5);
    return s;
  endfunction : mk
  // expected lane word when every select field holds code c
  function automatic logic [239:0] ew(input logic [3:0] c, input logic m,
                                      input logic [N_CH-1:0][SAMPLE_W-1:0] s);
    logic [N_POS-1:0][SAMPLE_W-1:0] a;
    logic [13:0] v;
    logic on;
    on = !(c[3] || (!m && c[0]));
    for (int p = 0; p < N_POS; p++) begin
      v = s[p < 4 ? int'(c[2:1]) : 7 - int'(c[2:1])];
      a[p] = !on ? 14'h0000 : !m ? v : c[0] ? {7'h00, v[13:7]} : {7'h00, v[6:0]};
    end
    return {a, a, {N_LANE{on}}};
  endfunction : ew
  // main sequence
  initial begin
    logic [239:0] w;
    logic [31:0] d;
    logic [1:0] r;
    logic [N_POS-1:0][SAMPLE_W-1:0] s, lo, hi;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < N_MAP; i++) begin
      rd(12'h140 + 12'(4 * i), d, r);
      chk(240'({r, d}), 240'({RESP_OKAY, 20'h0, MAP_RST[i]}));
    end
    s = mk(1);
    send(s);
    take(w);
    chk(w, {s, 112'h0, 16'h5555});
    wr(12'h158, 32'h1, r);
    for (int p = 0; p < N_POS; p++) begin
      lo[p] = {7'h00, s[p][6:0]};
      hi[p] = {7'h00, s[p][13:7]};
    end
    send(s);
    take(w);
    chk(w, {lo, hi, 16'hFFFF});
    for (int n = 0; n < 32; n++) begin
      if (!n[4] && n[0] && !n[3]) continue;
      wr(12'h158, {31'h0, n[4]}, r);
      for (int i = 0; i < N_MAP; i++) wr(12'h140 + 12'(4 * i), {20'h0, {3{n[3:0]}}}, r);
      @(posedge clk); // power-down flops follow the last map write one edge late
      chk(240'(lane_power_down), 240'({N_LANE{n[3]}}));
      s = mk(n);
      send(s);
      take(w);
      chk(w, ew(n[3:0], n[4], s));
    end
    rd(12'h200, d, r);
    chk(240'({r, d}), 240'({RESP_DECERR, 32'h0}));
    wr(12'h160, 32'h1, r);
    chk(240'(r), 240'(RESP_DECERR));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(12'h140, d, r);
    chk(240'(d), 240'(MAP_RST[0]));
    // answers held back by a slow master: mode bit reads its reset value, status write answers OKAY
    lag = 1'b1;
    rd(12'h158, d, r);
    chk(240'({r, d}), 240'({RESP_OKAY, 31'h0, CTRL_TWO_LANE_RST}));
    wr(12'h15C, 32'h1, r);
    chk(240'(r), 240'(RESP_OKAY));
    lag = 1'b0;
    stall <= 1'b1;
    send(mk(40));
    send(mk(41));
    repeat (2) @(posedge clk);
    chk(240'(sample_ready), 240'(1'b0));
    stall <= 1'b0;
    send(mk(42));
    for (int j = 40; j < 43; j++) begin
      s = mk(j);
      take(w);
      chk(w, {s, 112'h0, 16'h5555});
    end
    final_report();
  end
endmodule : aclm_lane_mapper_tb_top
bind aclm_lane_mapper aclm_lane_mapper_chk chk_i (.*);
